// ---- rtl/bbe_map.svh ----
// Purpose: Byte codes, lengths, status codes and rate table for the boot command block
// Assumes: Included by bare name from the design files
// Notes:   Definitions only
`ifndef BBE_MAP_SVH
`define BBE_MAP_SVH
// ****************************************
// Packet framing
// ****************************************
`define BBE_SOH         8'h01
`define BBE_SOD         8'h81
`define BBE_ETX         8'h03
`define BBE_CMD_BAUD    8'h34
`define BBE_CMD_ERASE   8'h12
`define BBE_RES_BAUD_ER 8'hB4
`define BBE_LEN_BAUD    16'h0005
`define BBE_LEN_ERASE   16'h0009
`define BBE_LEN_MAX     16'h0400
`define BBE_LEN_ZERO    16'h0000
`define BBE_LEN_ONE     16'h0001
`define BBE_CNT_CMD     16'h0000
`define BBE_CNT_F0_END  16'h0004
`define BBE_CNT_F1_END  16'h0008
`define BBE_RSP_LNH     8'h00
`define BBE_RSP_LNL     8'h0A
`define BBE_FILL        8'hFF
`define BBE_ZERO8       8'h00
// ****************************************
// Status codes
// ****************************************
`define BBE_STS_OK      8'h00
`define BBE_STS_PKT     8'hC1
`define BBE_STS_CSUM    8'hC2
`define BBE_STS_PARAM   8'hC3
// ****************************************
// Response byte positions
// ****************************************
`define BBE_IX_SOD      4'h0
`define BBE_IX_LNH      4'h1
`define BBE_IX_LNL      4'h2
`define BBE_IX_RES      4'h3
`define BBE_IX_STS      4'h4
`define BBE_IX_SUM      4'hD
`define BBE_IX_LAST     4'hE
`define BBE_IX_ONE      4'h1
// ****************************************
// Rates and settings {clock_select_bit, divisor, modulation}
// ****************************************
`define BBE_R9600       32'h00002580
`define BBE_R115K       32'h0001C200
`define BBE_R500K       32'h0007A120
`define BBE_R1M         32'h000F4240
`define BBE_R1M5        32'h0016E360
`define BBE_R2M         32'h001E8480
`define BBE_R4M         32'h003D0900
`define BBE_R6M         32'h005B8D80
`define BBE_A_9600      17'h0FFC9
`define BBE_A_115K      17'h01AFE
`define BBE_A_500K      17'h005F5
`define BBE_A_1M        17'h002F5
`define BBE_A_1M5       17'h001F5
`define BBE_A_2M        17'h000A3
`define BBE_A_4M        17'h100A3
`define BBE_A_6M        17'h100F5
`define BBE_D_9600      17'h0C2FF
`define BBE_D_115K      17'h00FFB
`define BBE_D_500K      17'h002CC
`define BBE_D_1M        17'h00088
`define BBE_D_1M5       17'h000CC
`define BBE_D_2M        17'h10088
`define BBE_SET_NONE    17'h00000
`define BBE_CKS         2'b00
`endif

// ---- rtl/bbe_pkg.sv ----
// Purpose: Types shared by the boot command block
// Assumes: Constants live in bbe_map.svh
// Notes:   Types only
package bbe_pkg;
	// Interpreter states
	typedef enum logic [3:0] {
		ST_WAIT, ST_LNH, ST_LNL, ST_BODY, ST_SUM, ST_ETX,
		ST_CHECK, ST_TX, ST_DRAIN, ST_ERASE
	} bbe_state_e;
	// Packed rate setting {clock_select_bit, divisor, modulation}
	typedef logic [16:0] bbe_rate_set_t;
endpackage : bbe_pkg

// ---- rtl/bbe_rate_lut.sv ----
// Purpose: Map a requested rate to serial baud generator settings
// Assumes: Purely combinational, same clock domain as the caller
// Notes:   Two device groups with different tables
`timescale 1ns/1ps
`include "bbe_map.svh"
module bbe_rate_lut (
	input  wire logic [31:0]           rate_i,     // Requested rate, bps
	input  wire logic                  group_d_i,  // Later device group table
	output logic                       ok_o,       // Rate supported
	output bbe_pkg::bbe_rate_set_t     set_o       // Settings for the rate
);
	// ****************************************
	// Lookup
	// ****************************************
	// Table per group; unsupported rates give zero settings
	always_comb
	begin
		ok_o  = 1'b1;
		set_o = `BBE_SET_NONE;
		case (rate_i)
			`BBE_R9600: set_o = group_d_i ? `BBE_D_9600 : `BBE_A_9600;
			`BBE_R115K: set_o = group_d_i ? `BBE_D_115K : `BBE_A_115K;
			`BBE_R500K: set_o = group_d_i ? `BBE_D_500K : `BBE_A_500K;
			`BBE_R1M:   set_o = group_d_i ? `BBE_D_1M : `BBE_A_1M;
			`BBE_R1M5:  set_o = group_d_i ? `BBE_D_1M5 : `BBE_A_1M5;
			`BBE_R2M:   set_o = group_d_i ? `BBE_D_2M : `BBE_A_2M;
			// Fast rates exist only on the first groups
			`BBE_R4M:
			begin
				ok_o  = !group_d_i;
				set_o = group_d_i ? `BBE_SET_NONE : `BBE_A_4M;
			end
			`BBE_R6M:
			begin
				ok_o  = !group_d_i;
				set_o = group_d_i ? `BBE_SET_NONE : `BBE_A_6M;
			end
			default: ok_o = 1'b0;
		endcase
	end
endmodule : bbe_rate_lut

// ---- rtl/bbe_cmd.sv ----
// Purpose: Boot command interpreter for the rate-set and erase commands
// Assumes: Byte streams on clk_i; uart_link_i and group_d_i are static levels
// Notes:   tx_idle_i must drop within one cycle of a byte being taken
//
// Contract
// - Hunt for start byte, drop others
// - Missing end byte gives packet error
// - Checksum mismatch gives checksum error
// - Bad lengths give packet error
// - Errors skip execution, return to wait
// - Non-serial link: answer OK, keep rate
// - Rate above reported maximum: parameter error
// - Unsupported rate: parameter error
// - OK first, then new rate, then wait
// - Error response layout with code 0xB4
// - Report highest priority error, fields all ones
// - First groups rate settings table
// - Later group rate settings table
// - Erase packet: 0x12, length nine, two addresses
// - Multi-byte fields most significant first
// - Erase unit by unit, start to end
// - Erase ignores block protection bits
// - Rate packet: 0x34, length five
// - Rate is four bytes, bps, big-endian
// - Host waits rate setting time
`timescale 1ns/1ps
`include "bbe_map.svh"
module bbe_cmd (
	input  wire logic        clk_i,                 // Core clock, 100 MHz
	input  wire logic        nrst_i,                // Async reset, active low
	input  wire logic        rx_valid_i,            // Received byte strobe
	input  wire logic [7:0]  rx_data_i,             // Received byte
	output logic             tx_valid_o,            // Response byte valid
	output logic [7:0]       tx_data_o,             // Response byte
	input  wire logic        tx_ready_i,            // Transmitter takes byte
	input  wire logic        tx_idle_i,             // Last bit has left the line
	input  wire logic        uart_link_i,           // Active link is two-wire serial
	input  wire logic        group_d_i,             // Later device group
	input  wire logic [31:0] max_reported_rate_i,   // Maximum rate from signature
	output logic [7:0]       rate_divisor_o,        // Baud divisor
	output logic [7:0]       rate_modulation_o,     // Baud modulation
	output logic             clock_select_bit_o,    // Baud clock select
	output logic [1:0]       clock_prescale_o,      // Baud prescale
	output logic             rate_load_o,           // New settings pulse
	output logic             erase_req_o,           // Erase one unit
	output logic [31:0]      erase_addr_o,          // Address of that unit
	input  wire logic [31:0] erase_unit_i,          // Erase access unit, bytes
	input  wire logic        erase_done_i,          // Unit erased
	output logic             erase_ignore_protect_o,// Bypass protection bits
	output logic             cmd_wait_o             // Waiting for a command
);
	// ****************************************
	// State and storage
	// ****************************************
	bbe_pkg::bbe_state_e    state_q;      // Interpreter state
	logic [15:0]            len_q;        // Packet length field
	logic [15:0]            cnt_q;        // Body byte counter
	logic [7:0]             cmd_q;        // Command code
	logic [31:0]            f0_q;         // First field
	logic [31:0]            f1_q;         // Second field
	logic [7:0]             sum_q;        // Running packet sum
	logic                   etx_ok_q;     // End byte seen
	logic [3:0]             idx_q;        // Response byte index
	logic [7:0]             res_q;        // Response code
	logic [7:0]             sts_q;        // Status code
	logic [7:0]             txsum_q;      // Running response sum
	logic [7:0]             tx_data_q;    // Byte on offer
	logic                   load_pend_q;  // Rate change after response
	bbe_pkg::bbe_rate_set_t set_q;        // Settings awaiting load
	logic [31:0]            end_q;        // Erase end address
	logic [31:0]            addr_q;       // Current erase address
	logic                   load_q;       // Load pulse register
	logic [7:0]             div_q;        // Divisor register
	logic [7:0]             mod_q;        // Modulation register
	logic                   cs_q;         // Clock select register

	// ****************************************
	// Rate lookup
	// ****************************************
	logic                   rate_ok;      // Rate in table
	bbe_pkg::bbe_rate_set_t rate_set;     // Settings for the rate
	bbe_rate_lut u_lut (
		.rate_i    (f0_q),
		.group_d_i (group_d_i),
		.ok_o      (rate_ok),
		.set_o     (rate_set)
	);

	// ****************************************
	// Packet analysis
	// ****************************************
	logic       chk_rsp;   // Send a response
	logic [7:0] chk_res;   // Its code
	logic [7:0] chk_sts;   // Its status
	logic       chk_load;  // Change rate after it
	logic       chk_erase; // Start erase
	logic       tx_take;   // Byte handed over
	logic [7:0] sum_nx;    // Response sum incl. current byte
	logic [7:0] byte_nx;   // Next response byte
	logic [32:0] addr_nx;  // Next erase address, with carry

	// Checks in priority order; first hit wins
	always_comb
	begin
		chk_rsp   = 1'b0;
		chk_res   = `BBE_RES_BAUD_ER;
		chk_sts   = `BBE_STS_OK;
		chk_load  = 1'b0;
		chk_erase = 1'b0;
		if (!etx_ok_q)
		begin
			chk_rsp = 1'b1;
			chk_sts = `BBE_STS_PKT;
		end
		else if (sum_q != `BBE_ZERO8)
		begin
			chk_rsp = 1'b1;
			chk_sts = `BBE_STS_CSUM;
		end
		else if (len_q == `BBE_LEN_ZERO || len_q > `BBE_LEN_MAX)
		begin
			chk_rsp = 1'b1;
			chk_sts = `BBE_STS_PKT;
		end
		else if ((cmd_q == `BBE_CMD_BAUD && len_q != `BBE_LEN_BAUD) ||
			(cmd_q == `BBE_CMD_ERASE && len_q != `BBE_LEN_ERASE))
		begin
			chk_rsp = 1'b1;
			chk_sts = `BBE_STS_PKT;
		end
		else if (cmd_q == `BBE_CMD_BAUD)
		begin
			chk_rsp = 1'b1;
			if (!uart_link_i)
			begin
				chk_res = `BBE_CMD_BAUD;
			end
			else if (f0_q > max_reported_rate_i)
			begin
				chk_sts = `BBE_STS_PARAM;
			end
			else if (!rate_ok)
			begin
				chk_sts = `BBE_STS_PARAM;
			end
			else
			begin
				chk_res  = `BBE_CMD_BAUD;
				chk_load = 1'b1;
			end
		end
		else if (cmd_q == `BBE_CMD_ERASE)
		begin
			chk_erase = 1'b1;
		end
		else
		begin
			// Other commands are not handled here
			chk_rsp = 1'b0;
		end
	end

	// ****************************************
	// Response builder
	// ****************************************
	assign tx_take = (state_q == bbe_pkg::ST_TX) && tx_ready_i;
	// Start byte is outside the sum
	assign sum_nx = (idx_q == `BBE_IX_SOD) ? `BBE_ZERO8 : (txsum_q + tx_data_q);

	// Byte that follows the one on offer
	always_comb
	begin
		case (idx_q + `BBE_IX_ONE)
			`BBE_IX_LNH: byte_nx = `BBE_RSP_LNH;
			`BBE_IX_LNL: byte_nx = `BBE_RSP_LNL;
			`BBE_IX_RES: byte_nx = res_q;
			`BBE_IX_STS: byte_nx = sts_q;
			`BBE_IX_SUM: byte_nx = `BBE_ZERO8 - sum_nx;
			`BBE_IX_LAST: byte_nx = `BBE_ETX;
			default: byte_nx = `BBE_FILL;
		endcase
	end

	// ****************************************
	// Interpreter sequence
	// ****************************************
	assign addr_nx = {1'b0, addr_q} + {1'b0, erase_unit_i};

	// Main state machine
	always_ff @(posedge clk_i or negedge nrst_i)
	begin
		if (!nrst_i)
		begin
			state_q <= bbe_pkg::ST_WAIT;
		end
		else
		begin
			case (state_q)
				bbe_pkg::ST_WAIT:
					if (rx_valid_i && rx_data_i == `BBE_SOH)
						state_q <= bbe_pkg::ST_LNH;
				bbe_pkg::ST_LNH:
					if (rx_valid_i)
						state_q <= bbe_pkg::ST_LNL;
				bbe_pkg::ST_LNL:
					if (rx_valid_i)
						state_q <= ({len_q[15:8], rx_data_i} == `BBE_LEN_ZERO) ?
							bbe_pkg::ST_SUM : bbe_pkg::ST_BODY;
				bbe_pkg::ST_BODY:
					if (rx_valid_i && cnt_q == len_q - `BBE_LEN_ONE)
						state_q <= bbe_pkg::ST_SUM;
				bbe_pkg::ST_SUM:
					if (rx_valid_i)
						state_q <= bbe_pkg::ST_ETX;
				bbe_pkg::ST_ETX:
					if (rx_valid_i)
						state_q <= bbe_pkg::ST_CHECK;
				bbe_pkg::ST_CHECK:
					// Errors drop straight back after the answer
					if (chk_rsp)
						state_q <= bbe_pkg::ST_TX;
					else if (chk_erase)
						state_q <= bbe_pkg::ST_ERASE;
					else
						state_q <= bbe_pkg::ST_WAIT;
				bbe_pkg::ST_TX:
					if (tx_take && idx_q == `BBE_IX_LAST)
						state_q <= load_pend_q ? bbe_pkg::ST_DRAIN : bbe_pkg::ST_WAIT;
				bbe_pkg::ST_DRAIN:
					// Old rate holds until the line is quiet
					if (tx_idle_i)
						state_q <= bbe_pkg::ST_WAIT;
				bbe_pkg::ST_ERASE:
					// Unaligned ends are the host's problem
					if (erase_done_i && (addr_nx[32] || addr_nx[31:0] > end_q ||
						erase_unit_i == 32'h0000_0000))
						state_q <= bbe_pkg::ST_WAIT;
				default: state_q <= bbe_pkg::ST_WAIT;
			endcase
		end
	end

	// Packet capture, fields shifted in big-endian
	always_ff @(posedge clk_i or negedge nrst_i)
	begin
		if (!nrst_i)
		begin
			len_q    <= `BBE_LEN_ZERO;
			cnt_q    <= `BBE_LEN_ZERO;
			cmd_q    <= `BBE_ZERO8;
			f0_q     <= 32'h0000_0000;
			f1_q     <= 32'h0000_0000;
			sum_q    <= `BBE_ZERO8;
			etx_ok_q <= 1'b0;
		end
		else if (rx_valid_i)
		begin
			case (state_q)
				bbe_pkg::ST_WAIT:
				begin
					sum_q <= `BBE_ZERO8;
					cnt_q <= `BBE_LEN_ZERO;
				end
				bbe_pkg::ST_LNH:
				begin
					len_q <= {rx_data_i, `BBE_ZERO8};
					sum_q <= sum_q + rx_data_i;
				end
				bbe_pkg::ST_LNL:
				begin
					len_q <= {len_q[15:8], rx_data_i};
					sum_q <= sum_q + rx_data_i;
				end
				bbe_pkg::ST_BODY:
				begin
					sum_q <= sum_q + rx_data_i;
					cnt_q <= cnt_q + `BBE_LEN_ONE;
					if (cnt_q == `BBE_CNT_CMD)
						cmd_q <= rx_data_i;
					else if (cnt_q <= `BBE_CNT_F0_END)
						f0_q <= {f0_q[23:0], rx_data_i};
					else if (cnt_q <= `BBE_CNT_F1_END)
						f1_q <= {f1_q[23:0], rx_data_i};
				end
				bbe_pkg::ST_SUM: sum_q <= sum_q + rx_data_i;
				bbe_pkg::ST_ETX: etx_ok_q <= (rx_data_i == `BBE_ETX);
				default: etx_ok_q <= etx_ok_q;
			endcase
		end
	end

	// Response registers
	always_ff @(posedge clk_i or negedge nrst_i)
	begin
		if (!nrst_i)
		begin
			idx_q       <= `BBE_IX_SOD;
			res_q       <= `BBE_ZERO8;
			sts_q       <= `BBE_ZERO8;
			txsum_q     <= `BBE_ZERO8;
			tx_data_q   <= `BBE_ZERO8;
			load_pend_q <= 1'b0;
			set_q       <= `BBE_SET_NONE;
		end
		else if (state_q == bbe_pkg::ST_CHECK)
		begin
			idx_q       <= `BBE_IX_SOD;
			res_q       <= chk_res;
			sts_q       <= chk_sts;
			txsum_q     <= `BBE_ZERO8;
			tx_data_q   <= `BBE_SOD;
			load_pend_q <= chk_rsp && chk_load;
			set_q       <= rate_set;
		end
		else if (tx_take && idx_q != `BBE_IX_LAST)
		begin
			idx_q     <= idx_q + `BBE_IX_ONE;
			txsum_q   <= sum_nx;
			tx_data_q <= byte_nx;
		end
	end

	// Baud generator settings, loaded once the line is idle
	always_ff @(posedge clk_i or negedge nrst_i)
	begin
		if (!nrst_i)
		begin
			load_q <= 1'b0;
			div_q  <= `BBE_ZERO8;
			mod_q  <= `BBE_ZERO8;
			cs_q   <= 1'b0;
		end
		else
		begin
			load_q <= (state_q == bbe_pkg::ST_DRAIN) && tx_idle_i;
			if (state_q == bbe_pkg::ST_DRAIN && tx_idle_i)
			begin
				{cs_q, div_q, mod_q} <= set_q;
			end
		end
	end

	// Erase walk from start to end
	always_ff @(posedge clk_i or negedge nrst_i)
	begin
		if (!nrst_i)
		begin
			addr_q <= 32'h0000_0000;
			end_q  <= 32'h0000_0000;
		end
		else if (state_q == bbe_pkg::ST_CHECK && chk_erase)
		begin
			addr_q <= f0_q;
			end_q  <= f1_q;
		end
		else if (state_q == bbe_pkg::ST_ERASE && erase_done_i)
		begin
			addr_q <= addr_nx[31:0];
		end
	end

	// ****************************************
	// Outputs
	// ****************************************
	assign tx_valid_o             = (state_q == bbe_pkg::ST_TX);
	assign tx_data_o              = tx_data_q;
	assign rate_divisor_o         = div_q;
	assign rate_modulation_o      = mod_q;
	assign clock_select_bit_o     = cs_q;
	assign clock_prescale_o       = `BBE_CKS;
	assign rate_load_o            = load_q;
	assign erase_req_o            = (state_q == bbe_pkg::ST_ERASE);
	assign erase_addr_o           = addr_q;
	assign erase_ignore_protect_o = (state_q == bbe_pkg::ST_ERASE);
	assign cmd_wait_o             = (state_q == bbe_pkg::ST_WAIT);

	// ****************************************
	// Checks
	// ****************************************
	a_wait_hunt: assert property (@(posedge clk_i) disable iff (!nrst_i)
		(state_q == bbe_pkg::ST_WAIT && rx_valid_i && rx_data_i != `BBE_SOH)
		|=> state_q == bbe_pkg::ST_WAIT)
		else $error("non-start byte left wait");
	a_etx_first: assert property (@(posedge clk_i) disable iff (!nrst_i)
		(state_q == bbe_pkg::ST_CHECK && !etx_ok_q)
		|=> state_q == bbe_pkg::ST_TX && sts_q == `BBE_STS_PKT)
		else $error("missing end byte not reported");
	a_sum_error: assert property (@(posedge clk_i) disable iff (!nrst_i)
		(state_q == bbe_pkg::ST_CHECK && etx_ok_q && sum_q != `BBE_ZERO8)
		|=> sts_q == `BBE_STS_CSUM)
		else $error("checksum error not reported");
	a_len_error: assert property (@(posedge clk_i) disable iff (!nrst_i)
		(state_q == bbe_pkg::ST_CHECK && etx_ok_q && sum_q == `BBE_ZERO8 &&
		cmd_q == `BBE_CMD_BAUD && len_q != `BBE_LEN_BAUD)
		|=> sts_q == `BBE_STS_PKT && !load_pend_q)
		else $error("bad length not reported");
	a_no_change: assert property (@(posedge clk_i) disable iff (!nrst_i)
		(state_q == bbe_pkg::ST_CHECK && !uart_link_i)
		|=> !load_pend_q && res_q != `BBE_CMD_ERASE)
		else $error("rate change armed off serial link");
	a_rate_max: assert property (@(posedge clk_i) disable iff (!nrst_i)
		(state_q == bbe_pkg::ST_CHECK && etx_ok_q && sum_q == `BBE_ZERO8 &&
		cmd_q == `BBE_CMD_BAUD && len_q == `BBE_LEN_BAUD && uart_link_i &&
		f0_q > max_reported_rate_i)
		|=> sts_q == `BBE_STS_PARAM && !load_pend_q)
		else $error("rate above maximum accepted");
	a_load_idle: assert property (@(posedge clk_i) disable iff (!nrst_i)
		rate_load_o |-> $past(state_q == bbe_pkg::ST_DRAIN) && $past(tx_idle_i))
		else $error("rate loaded before line idle");
	a_ok_then_set: assert property (@(posedge clk_i) disable iff (!nrst_i)
		(tx_take && idx_q == `BBE_IX_LAST && load_pend_q)
		|=> state_q == bbe_pkg::ST_DRAIN ##[0:300] rate_load_o)
		else $error("rate not set after OK");
	a_sum_byte: assert property (@(posedge clk_i) disable iff (!nrst_i)
		(tx_valid_o && idx_q == `BBE_IX_SUM) |-> tx_data_q + txsum_q == `BBE_ZERO8)
		else $error("response checksum wrong");
	a_erase_step: assert property (@(posedge clk_i) disable iff (!nrst_i)
		(erase_req_o && erase_done_i && state_q == bbe_pkg::ST_ERASE)
		|=> addr_q == $past(addr_q) + $past(erase_unit_i))
		else $error("erase address did not step by unit");
	a_err_no_exec: assert property (@(posedge clk_i) disable iff (!nrst_i)
		(state_q == bbe_pkg::ST_CHECK && chk_sts != `BBE_STS_OK)
		|=> !erase_req_o ##1 !rate_load_o)
		else $error("execution after error");
endmodule : bbe_cmd

// ---- tb/bbe_tx_model.sv ----
// Purpose: Serial transmitter stand-in that drains response bytes
// Assumes: One byte taken per handshake on clk_i
// Notes:   Idle drops the cycle after a take; slow_i stretches bytes
`timescale 1ns/1ps
module bbe_tx_model (
	input  wire logic       clk_i,   // Core clock
	input  wire logic       nrst_i,  // Async reset, active low
	input  wire logic       slow_i,  // Long byte time
	input  wire logic       valid_i, // Byte on offer
	input  wire logic [7:0] data_i,  // Byte offered
	output logic            ready_o, // Take this edge
	output logic            idle_o   // Last bit has left
);
	logic [7:0] busy_q; // Bit times left
	logic [7:0] q[$];   // Bytes seen on the line
	// No holding buffer, so ready and idle coincide
	assign ready_o = (busy_q == 8'h00);
	assign idle_o  = (busy_q == 8'h00);
	// Shifter busy after each take
	always @(posedge clk_i or negedge nrst_i)
	begin
		if (!nrst_i)
			busy_q <= 8'h00;
		else if (valid_i && ready_o)
		begin
			busy_q <= slow_i ? 8'h28 : 8'h03;
			q.push_back(data_i);
		end
		else if (busy_q != 8'h00)
			busy_q <= busy_q - 8'h01;
	end
endmodule : bbe_tx_model

// ---- tb/bbe_cmd_bench.sv ----
// Purpose: Self-checking bench for the boot command block
// Assumes: Transmitter model on the response side
// Notes:   Host gap after a rate change kept by idle waits
`timescale 1ns/1ps
`include "bbe_map.svh"
`define CHK(nm, e, g) begin n_tests++; if ((g) !== (e)) begin errors++; \
	$display("CHECK FAILED %s expected %0h seen %0h", nm, e, g); end end
module bbe_cmd_bench;
	logic        clk_i = 1'b0, nrst_i = 1'b0, rx_valid_i = 1'b0, uart_link_i = 1'b1;
	logic        group_d_i = 1'b0, erase_done_i = 1'b0, slow = 1'b0;
	logic [7:0]  rx_data_i = 8'h00;
	logic [31:0] max_r = `BBE_R6M, erase_unit_i = 32'h00000100;
	logic        tx_valid_o, tx_ready_i, tx_idle_i, clock_select_bit_o, rate_load_o;
	logic        erase_req_o, erase_ignore_protect_o, cmd_wait_o;
	logic [7:0]  tx_data_o, rate_divisor_o, rate_modulation_o;
	logic [1:0]  clock_prescale_o;
	logic [31:0] erase_addr_o;
	int          errors = 0, n_tests = 0, cyc = 0;
	logic [31:0] rt[8] = '{`BBE_R9600, `BBE_R115K, `BBE_R500K, `BBE_R1M, `BBE_R1M5,
		`BBE_R2M, `BBE_R4M, `BBE_R6M};
	logic [16:0] sa[8] = '{17'h0FFC9, 17'h01AFE, 17'h005F5, 17'h002F5, 17'h001F5,
		17'h000A3, 17'h100A3, 17'h100F5};
	logic [16:0] sd[6] = '{17'h0C2FF, 17'h00FFB, 17'h002CC, 17'h00088, 17'h000CC, 17'h10088};
	bbe_cmd DUT (.clk_i(clk_i), .nrst_i(nrst_i), .rx_valid_i(rx_valid_i),
		.rx_data_i(rx_data_i), .tx_valid_o(tx_valid_o), .tx_data_o(tx_data_o),
		.tx_ready_i(tx_ready_i), .tx_idle_i(tx_idle_i), .uart_link_i(uart_link_i),
		.group_d_i(group_d_i), .max_reported_rate_i(max_r), .rate_divisor_o(rate_divisor_o),
		.rate_modulation_o(rate_modulation_o), .clock_select_bit_o(clock_select_bit_o),
		.clock_prescale_o(clock_prescale_o), .rate_load_o(rate_load_o),
		.erase_req_o(erase_req_o), .erase_addr_o(erase_addr_o), .erase_unit_i(erase_unit_i),
		.erase_done_i(erase_done_i), .erase_ignore_protect_o(erase_ignore_protect_o),
		.cmd_wait_o(cmd_wait_o));
	bbe_tx_model tm (.clk_i(clk_i), .nrst_i(nrst_i), .slow_i(slow), .valid_i(tx_valid_o),
		.data_i(tx_data_o), .ready_o(tx_ready_i), .idle_o(tx_idle_i));
	// 100 MHz clock
	initial
	begin
		forever #5 clk_i = ~clk_i;
	end
	// Verdict and end of run
	task automatic final_report();
		$display("comparisons %0d mismatches %0d", n_tests, errors);
		if (errors == 0 && n_tests > 0)
			$display("TEST PASSED");
		else
			$display("TEST FAILED");
		$finish;
	endtask : final_report
	// Hang guard, far above the expected run
	always @(posedge clk_i)
	begin
		cyc++;
		if (cyc == 40000)
		begin
			errors++;
			final_report();
		end
	end
	// One received byte per edge
	task automatic send(input logic [7:0] b);
		@(posedge clk_i);
		rx_valid_i <= 1'b1;
		rx_data_i  <= b;
	endtask : send
	// Whole packet, fields most significant byte first; bad sum or end on request
	task automatic pkt(input logic [15:0] len, input logic [7:0] cmd, input logic [63:0] f,
		input int nb, input logic [7:0] sb, input logic [7:0] packet_end_byte);
		logic [7:0] s;
		s = len[15:8] + len[7:0] + cmd;
		send(`BBE_SOH);
		send(len[15:8]);
		send(len[7:0]);
		send(cmd);
		for (int i = 0; i < nb; i++)
		begin
			s = s + f[63 - 8 * i -: 8];
			send(f[63 - 8 * i -: 8]);
		end
		send(8'h00 - s + sb);
		send(packet_end_byte);
		@(posedge clk_i);
		rx_valid_i <= 1'b0;
	endtask : pkt
	// Collect and compare a full response
	task automatic rsp(input logic [7:0] res, input logic [7:0] sts);
		logic [7:0] e[15];
		foreach (e[i]) e[i] = 8'hFF;
		e[0] = 8'h81; e[1] = 8'h00; e[2] = 8'h0A; e[3] = res; e[4] = sts; e[14] = 8'h03;
		e[13] = 8'h00 - 8'h0A - res - sts - 8'hF8;
		for (int k = 0; k < 2000 && tm.q.size() < 15; k++)
			@(posedge clk_i);
		`CHK("rsp count", 15, tm.q.size())
		foreach (e[i]) `CHK("rsp byte", e[i], tm.q[i])
		tm.q.delete();
	endtask : rsp
	// Settings may only move after the line is idle
	task automatic rate_ok(input logic [31:0] r, input logic [16:0] set);
		pkt(`BBE_LEN_BAUD, `BBE_CMD_BAUD, {r, 32'h0}, 4, 8'h00, `BBE_ETX);
		rsp(8'h34, 8'h00);
		for (int k = 0; k < 300 && rate_load_o !== 1'b1; k++)
			@(posedge clk_i);
		`CHK("load idle", 1'b1, tx_idle_i)
		`CHK("settings", set, {clock_select_bit_o, rate_divisor_o, rate_modulation_o})
		`CHK("prescale", 2'b00, clock_prescale_o)
		// Shortened host gap; the device does not time it, full 1ms is too long
		repeat (4) @(posedge clk_i);
		`CHK("back to wait", 1'b1, cmd_wait_o)
	endtask : rate_ok
	// Rejected or link-only packet: answer, then no rate change
	task automatic bad(input logic [15:0] len, input logic [31:0] r, input int nb,
		input logic [7:0] sb, input logic [7:0] packet_end_byte, input logic [7:0] res, input logic [7:0] sts);
		int hits;
		hits = 0;
		pkt(len, `BBE_CMD_BAUD, {r, 32'h0}, nb, sb, packet_end_byte);
		rsp(res, sts);
		repeat (80) @(posedge clk_i) hits += rate_load_o;
		`CHK("no load", 0, hits)
		`CHK("wait again", 1'b1, cmd_wait_o)
	endtask : bad
	// Main sequence
	initial
	begin
		repeat (16) @(posedge clk_i);
		nrst_i <= 1'b1;
		@(posedge clk_i);
		`CHK("reset wait", 1'b1, cmd_wait_o)
		send(8'h55);
		send(8'h03);
		foreach (rt[i]) rate_ok(rt[i], sa[i]);
		bad(`BBE_LEN_BAUD, `BBE_R115K, 4, 8'h01, 8'h55, 8'hB4, 8'hC1);
		bad(`BBE_LEN_BAUD, `BBE_R115K, 4, 8'h01, `BBE_ETX, 8'hB4, 8'hC2);
		bad(16'h0006, `BBE_R115K, 5, 8'h00, `BBE_ETX, 8'hB4, 8'hC1);
		bad(16'h0006, `BBE_R115K, 5, 8'h01, `BBE_ETX, 8'hB4, 8'hC2);
		bad(`BBE_LEN_BAUD, 32'h00003039, 4, 8'h00, `BBE_ETX, 8'hB4, 8'hC3);
		max_r <= `BBE_R1M;
		bad(`BBE_LEN_BAUD, `BBE_R2M, 4, 8'h00, `BBE_ETX, 8'hB4, 8'hC3);
		max_r <= `BBE_R6M;
		group_d_i <= 1'b1;
		slow <= 1'b1;
		foreach (sd[i]) rate_ok(rt[i], sd[i]);
		bad(`BBE_LEN_BAUD, `BBE_R4M, 4, 8'h00, `BBE_ETX, 8'hB4, 8'hC3);
		uart_link_i <= 1'b0;
		bad(`BBE_LEN_BAUD, `BBE_R9600, 4, 8'h00, `BBE_ETX, 8'h34, 8'h00);
		pkt(`BBE_LEN_ERASE, `BBE_CMD_ERASE, 64'h00000100_000003FF, 8, 8'h00, `BBE_ETX);
		for (int u = 1; u < 4; u++)
		begin
			for (int k = 0; k < 50 && erase_req_o !== 1'b1; k++)
				@(posedge clk_i);
			`CHK("erase addr", 32'h100 * u, erase_addr_o)
			`CHK("protect bypass", 1'b1, erase_ignore_protect_o)
			@(posedge clk_i) erase_done_i <= 1'b1;
			@(posedge clk_i) erase_done_i <= 1'b0;
			@(posedge clk_i);
		end
		`CHK("erase over", 1'b0, erase_req_o)
		`CHK("erase wait", 1'b1, cmd_wait_o)
		final_report();
	end
endmodule : bbe_cmd_bench
